// ---- common/tbl_pkg.sv ----
// Constants, encodings and shared helpers for the table access pointer block.
// Assumes a single core clock domain and an external flash array port.
package tbl_pkg;

  localparam int PTR_W        = 22;
  localparam int LOW_W        = 21;
  localparam int CFG_BIT      = 21;
  localparam int ERASE_LSB    = 6;
  localparam int FLAG_DONE    = 4;
  localparam logic [7:0]  LATCH_RST = 8'h00;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [21:0] PTR_RST   = 22'h000000;

  // Pointer update variants encoded by the core with each table operation
  typedef enum logic [1:0] {
    UPD_NONE     = 2'h0,
    UPD_POST_INC = 2'h1,
    UPD_POST_DEC = 2'h2,
    UPD_PRE_INC  = 2'h3
  } ptr_upd_e;

  // Special-function register selector on the core's register port
  typedef enum logic [2:0] {
    SEL_LATCH = 3'h0,
    SEL_UPPER = 3'h1,
    SEL_HIGH  = 3'h2,
    SEL_LOW   = 3'h3,
    SEL_FLAGS = 3'h4
  } reg_sel_e;

  // Step the lower 21 bits only, never carrying into the top bit
  function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic down);
    logic [20:0] lo;
    lo = down ? (p[20:0] - 21'h000001) : (p[20:0] + 21'h000001);
    ptr_step = {p[21], lo};
  endfunction : ptr_step

endpackage : tbl_pkg

// ---- hw/table_access_pointer.sv ----
// Table latch, 22-bit program pointer, holding block and write-complete flag.
// Assumes the core issues one operation at a time and waits on busy; the flash
// array answers reads in the cycle flash_rd is strobed and pulses nvm_op_done when done.
module table_access_pointer #(
  parameter int HOLD_BITS = 5
) (
  // Clock and reset
  input  wire  logic                   core_clk,
  input  wire  logic                   rst_n,
  // Core register port
  input  wire  logic                   reg_wr,
  input  wire  tbl_pkg::reg_sel_e      reg_sel,
  input  wire  logic [7:0]             reg_wdata,
  output logic [7:0]                   reg_rdata,
  // Core table operations
  input  wire  logic                   table_read_op,
  input  wire  logic                   table_write_op,
  input  wire  tbl_pkg::ptr_upd_e      op_upd,
  input  wire  logic                   nvm_write_start,
  input  wire  logic                   nvm_erase_start,
  output logic                         busy,
  // Flash array
  output logic                         flash_rd,
  output logic [21:0]                  flash_rd_addr,
  input  wire  logic [7:0]             flash_rd_data,
  output logic                         flash_wr,
  output logic                         flash_erase,
  output logic [21:0]                  flash_blk_addr,
  output logic [8*(2**HOLD_BITS)-1:0]  flash_wr_block,
  input  wire  logic                   nvm_op_done,
  // Flag output
  output logic                         nvm_write_done_flag
);
  import tbl_pkg::*;

  localparam int DEPTH = 2 ** HOLD_BITS;

  logic [7:0]  table_latch_byte_ff;
  logic [21:0] program_byte_pointer_ff;
  logic [7:0]  peripheral_flags_two_ff;
  logic [7:0]  hold_ff [DEPTH];
  logic        rd_pend_ff;
  logic        nvm_busy_ff;
  logic [21:0] rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Register readback

  always_comb begin
    case (reg_sel)
      SEL_LATCH: reg_rdata = table_latch_byte_ff;
      SEL_UPPER: reg_rdata = {2'h0, program_byte_pointer_ff[21:16]};
      SEL_HIGH:  reg_rdata = program_byte_pointer_ff[15:8];
      SEL_LOW:   reg_rdata = program_byte_pointer_ff[7:0];
      SEL_FLAGS: reg_rdata = peripheral_flags_two_ff;
      default:   reg_rdata = 8'h00;
    endcase
  end

  assign busy = rd_pend_ff | nvm_busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer: byte writes and automatic updates

  // Pre-increment uses the stepped pointer for the access itself
  assign rd_addr = (op_upd == UPD_PRE_INC) ? ptr_step(program_byte_pointer_ff, 1'b0)
                                           : program_byte_pointer_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      program_byte_pointer_ff <= PTR_RST;
    end else if ((table_read_op || table_write_op) && !busy) begin
      case (op_upd)
        UPD_NONE:     program_byte_pointer_ff <= program_byte_pointer_ff;
        UPD_POST_DEC: program_byte_pointer_ff <= ptr_step(program_byte_pointer_ff, 1'b1);
        default:      program_byte_pointer_ff <= ptr_step(program_byte_pointer_ff, 1'b0);
      endcase
    end else if (reg_wr) begin
      case (reg_sel)
        SEL_UPPER: program_byte_pointer_ff[21:16] <= reg_wdata[5:0];
        SEL_HIGH:  program_byte_pointer_ff[15:8]  <= reg_wdata;
        SEL_LOW:   program_byte_pointer_ff[7:0]   <= reg_wdata;
        default:   program_byte_pointer_ff <= program_byte_pointer_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table read: full 22-bit address, top bit picks configuration space

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_ff    <= 1'b0;
      flash_rd      <= 1'b0;
      flash_rd_addr <= PTR_RST;
    end else begin
      flash_rd   <= table_read_op && !busy;
      rd_pend_ff <= table_read_op && !busy;
      if (table_read_op && !busy) begin
        flash_rd_addr <= rd_addr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_latch_byte_ff <= LATCH_RST;
    end else if (rd_pend_ff) begin
      table_latch_byte_ff <= flash_rd_data;
    end else if (reg_wr && reg_sel == SEL_LATCH) begin
      table_latch_byte_ff <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table write into holding block; flash untouched

  always_ff @(posedge core_clk) begin
    if (table_write_op && !busy) begin
      hold_ff[rd_addr[HOLD_BITS-1:0]] <= table_latch_byte_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      flash_wr_block[8*i +: 8] = hold_ff[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block write and erase

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_busy_ff    <= 1'b0;
      flash_wr       <= 1'b0;
      flash_erase    <= 1'b0;
      flash_blk_addr <= PTR_RST;
    end else begin
      flash_wr    <= 1'b0;
      flash_erase <= 1'b0;
      if (!busy && nvm_erase_start) begin
        flash_erase    <= 1'b1;
        nvm_busy_ff    <= 1'b1;
        flash_blk_addr <= {program_byte_pointer_ff[21:ERASE_LSB], 6'h00};
      end else if (!busy && nvm_write_start) begin
        flash_wr       <= 1'b1;
        nvm_busy_ff    <= 1'b1;
        flash_blk_addr <= {program_byte_pointer_ff[21:HOLD_BITS], {HOLD_BITS{1'b0}}};
      end else if (nvm_op_done) begin
        nvm_busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags register; hardware set wins over software clear

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_flags_two_ff <= FLAGS_RST;
    end else begin
      if (reg_wr && reg_sel == SEL_FLAGS) begin
        peripheral_flags_two_ff <= reg_wdata;
      end
      if (nvm_busy_ff && nvm_op_done) begin
        peripheral_flags_two_ff[FLAG_DONE] <= 1'b1;
      end
    end
  end

  assign nvm_write_done_flag = peripheral_flags_two_ff[FLAG_DONE];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_rd_issue;
    table_read_op && !busy;
  endsequence

  AST_TOP_BIT_KEPT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (table_read_op || table_write_op) && !busy |=>
      program_byte_pointer_ff[CFG_BIT] == $past(program_byte_pointer_ff[CFG_BIT]))
    else $error("pointer top bit changed by auto update");

  AST_RD_LATCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_rd_issue ##1 1'b1 |=> table_latch_byte_ff == $past(flash_rd_data))
    else $error("read byte not loaded into latch");

  AST_RD_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_rd_issue |=> flash_rd && flash_rd_addr == $past(rd_addr))
    else $error("read address wrong");

  AST_POST_INC: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_rd_issue and (op_upd == UPD_POST_INC)) |=>
      program_byte_pointer_ff[20:0] == $past(program_byte_pointer_ff[20:0]) + 21'h000001)
    else $error("post increment wrong");

  AST_POST_DEC: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_rd_issue and (op_upd == UPD_POST_DEC)) |=>
      program_byte_pointer_ff[20:0] == $past(program_byte_pointer_ff[20:0]) - 21'h000001)
    else $error("post decrement wrong");

  AST_NO_CHANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_rd_issue and (op_upd == UPD_NONE)) |=> $stable(program_byte_pointer_ff))
    else $error("pointer moved on no-change variant");

  AST_ERASE_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
    flash_erase |-> flash_blk_addr[5:0] == 6'h00)
    else $error("erase address not block aligned");

  AST_WR_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
    flash_wr |-> flash_blk_addr[HOLD_BITS-1:0] == '0)
    else $error("write block address not aligned");

  AST_FLASH_WR_ONLY_CMD: assert property (@(posedge core_clk) disable iff (!rst_n)
    flash_wr |-> $past(nvm_write_start))
    else $error("flash written without write command");

  AST_DONE_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    nvm_busy_ff && nvm_op_done |=> nvm_write_done_flag)
    else $error("done flag not set on completion");

endmodule : table_access_pointer

// ---- sim/flash_model.sv ----
// Flash array partner: read data, block write and erase completion.
// Assumes the design strobes flash_rd, flash_wr and flash_erase for one cycle.
module flash_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Read side
  input  wire logic        flash_rd,
  input  wire logic [21:0] flash_rd_addr,
  output logic      [7:0]  flash_rd_data,
  // Write and erase side
  input  wire logic        flash_wr,
  input  wire logic        flash_erase,
  input  wire logic [3:0]  done_dly,
  output logic             nvm_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] junk;
  int         cnt;
  // Data is valid only while a read is strobed; otherwise it keeps changing
  assign flash_rd_data = flash_rd ? (flash_rd_addr[7:0] ^ {flash_rd_addr[21],
                         flash_rd_addr[14:8]}) : junk;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) junk <= 8'h5A;
    else junk <= junk + 8'h3B;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      nvm_op_done <= 1'b0;
    end else begin
      nvm_op_done <= (cnt == 1);
      if (flash_wr || flash_erase) cnt <= int'(done_dly) + 2;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : flash_model

// ---- sim/table_access_pointer_bench.sv ----
// Bench: boundary and random table traffic against a reference model.
// Assumes tbl_pkg and flash_model are compiled first.
module table_access_pointer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tbl_pkg::*;
  localparam int HB = 4;
  logic            core_clk = 0, rst_n = 0, reg_wr = 0, table_read_op = 0, table_write_op = 0;
  logic            nvm_write_start = 0, nvm_erase_start = 0;
  reg_sel_e        reg_sel = SEL_LATCH;
  ptr_upd_e        op_upd = UPD_NONE;
  logic [7:0]      reg_wdata = 8'h00, reg_rdata, flash_rd_data, ml = 8'h00, mf = 8'h00;
  logic [7:0]      mh [16];
  logic [21:0]     flash_rd_addr, flash_blk_addr, mp = 22'h000000;
  logic [127:0]    flash_wr_block;
  logic            busy, flash_rd, flash_wr, flash_erase, nvm_op_done, nvm_write_done_flag;
  logic [3:0]      done_dly = 4'h0;
  logic [31:0]     r;
  int              seed = 34, failures = 0, cmp_count = 0, cyc = 0;
  table_access_pointer #(.HOLD_BITS(HB)) i_table_access_pointer (.core_clk, .rst_n, .reg_wr,
    .reg_sel, .reg_wdata, .reg_rdata, .table_read_op, .table_write_op, .op_upd,
    .nvm_write_start, .nvm_erase_start, .busy, .flash_rd, .flash_rd_addr, .flash_rd_data,
    .flash_wr, .flash_erase, .flash_blk_addr, .flash_wr_block, .nvm_op_done,
    .nvm_write_done_flag);
  flash_model i_flash_model (.core_clk, .rst_n, .flash_rd, .flash_rd_addr, .flash_rd_data,
    .flash_wr, .flash_erase, .done_dly, .nvm_op_done);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t byte got %h exp %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_addr(input logic [21:0] g, input logic [21:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t address got %h exp %h", $time, g, e);
    end
  endtask : chk_addr
  function automatic logic [21:0] stp(input logic [21:0] p, input logic dn);
    stp = {p[21], dn ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001};
  endfunction : stp
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wreg(input reg_sel_e s, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_sel = s;
    reg_wdata = d;
    tick;
    reg_wr = 1'b0;
    tick;
    case (s)
      SEL_LATCH: ml = d;
      SEL_UPPER: mp[21:16] = d[5:0];
      SEL_HIGH:  mp[15:8] = d;
      SEL_LOW:   mp[7:0] = d;
      SEL_FLAGS: mf = d;
      default: ;
    endcase
  endtask : wreg
  task automatic rd(input reg_sel_e s, input logic [7:0] e);
    reg_sel = s;
    tick;
    chk_reg(reg_rdata, e);
  endtask : rd
  task automatic setp(input logic [21:0] p);
    wreg(SEL_LOW, p[7:0]);
    wreg(SEL_HIGH, p[15:8]);
    wreg(SEL_UPPER, {2'h0, p[21:16]});
  endtask : setp
  task automatic chkp;
    rd(SEL_LOW, mp[7:0]);
    rd(SEL_HIGH, mp[15:8]);
    rd(SEL_UPPER, {2'h0, mp[21:16]});
  endtask : chkp
  task automatic top(input logic rdop, input ptr_upd_e u);
    logic [21:0] a;
    if (u == UPD_PRE_INC) mp = stp(mp, 1'b0);
    a = mp;
    table_read_op = rdop;
    table_write_op = !rdop;
    op_upd = u;
    tick;
    table_read_op = 1'b0;
    table_write_op = 1'b0;
    chk_reg({6'h00, flash_wr, flash_erase}, 8'h00);
    chk_reg({7'h00, flash_rd}, {7'h00, rdop});
    if (rdop) begin
      chk_addr(flash_rd_addr, a);
      ml = a[7:0] ^ {a[21], a[14:8]};
    end else mh[a[HB-1:0]] = ml;
    if (u == UPD_POST_INC || u == UPD_POST_DEC) mp = stp(mp, u == UPD_POST_DEC);
    tick;
    rd(SEL_LATCH, ml);
    chkp;
  endtask : top
  task automatic nvm(input logic er);
    logic [7:0] d;
    nvm_erase_start = er;
    nvm_write_start = !er;
    done_dly = 4'($random(seed));
    tick;
    nvm_erase_start = 1'b0;
    nvm_write_start = 1'b0;
    chk_reg({6'h00, flash_erase, flash_wr, busy}, {5'h00, er, !er, 1'b1});
    chk_addr(flash_blk_addr, er ? {mp[21:6], 6'h00} : {mp[21:HB], 4'h0});
    for (int i = 0; i < 16; i++) if (!er) chk_reg(flash_wr_block[8*i+:8], mh[i]);
    for (int n = 0; n < 40 && nvm_op_done !== 1'b1; n++) tick;
    // Odd delays write the flags with the done bit clear on the very edge that sets it
    if (done_dly[0]) begin
      d = 8'($random(seed)) & 8'hEF;
      wreg(SEL_FLAGS, d);
      mf = d | 8'h10;
    end else mf[4] = 1'b1;
    rd(SEL_FLAGS, mf);
    d = 8'($random(seed)) & 8'hEF;
    wreg(SEL_FLAGS, d);
    rd(SEL_FLAGS, d);
    chk_reg({7'h00, nvm_write_done_flag}, 8'h00);
  endtask : nvm
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    rd(SEL_LATCH, 8'h00);
    rd(SEL_FLAGS, 8'h00);
    chkp;
    wreg(reg_sel_e'(3'h5), 8'hFF);
    rd(reg_sel_e'(3'h5), 8'h00);
    // Holding block is not reset: fill every entry before any block write
    for (int i = 0; i < 16; i++) begin
      setp(22'(i));
      wreg(SEL_LATCH, 8'($random(seed)));
      top(1'b0, UPD_NONE);
    end
    for (int i = 0; i < 16; i++) begin
      setp(i[0] ? 22'h3FFFFF : 22'h200000);
      top(i[1], ptr_upd_e'(i[3:2]));
    end
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'h0, 3'h1: top(r[3], ptr_upd_e'(r[5:4]));
        3'h2: nvm(1'b0);
        3'h3: nvm(1'b1);
        3'h4: wreg(SEL_LATCH, r[15:8]);
        default: setp(r[9] ? {r[8], {21{r[7]}}} : r[31:10]);
      endcase
    end
    conclude;
  end
endmodule : table_access_pointer_bench
